/* File: flash_read_pkg.sv */
// constants and types for the multi-lane flash read front end
// Function
// - fast read: opcode, address, eight idle clocks
// - output line meaningless during fast read idle
// - dual output read returns two bits per clock
// - dual and quad output reads wait eight clocks
// - quad output read returns four bits per clock
// - quad output read needs the permit bit
// - dual address read: address on two lanes
// - mode byte follows address, low nibble ignored
// - skip field 10 drops next opcode
// - other skip field values restore opcode decoding
// - quad address read: four lanes, four idles
// - quad address read needs the permit bit
// - wrap keeps output inside aligned page section
// - three-bit wrap setting: off bit, length
// - word quad read waits two idle clocks
// - word quad read needs permit bit
// - address advances by one per byte
// - reads ignored while device is busy
// - wrap setting resets to off, lengths 8-64
// - all-ones pattern leaves continuous read mode
package flash_read_pkg;
	// ==========================================================
	// instruction codes
	localparam logic [7:0] op_fast_read = 8'h0b;
	localparam logic [7:0] op_dual_out = 8'h3b;
	localparam logic [7:0] op_quad_out = 8'h6b;
	localparam logic [7:0] op_dual_io = 8'hbb;
	localparam logic [7:0] op_quad_io = 8'heb;
	localparam logic [7:0] op_word_quad = 8'he7;
	// ==========================================================
	// phase lengths in link clocks
	localparam logic [5:0] opcode_clocks = 6'h08;
	localparam logic [5:0] addr_clocks_single = 6'h18;
	localparam logic [5:0] addr_clocks_dual = 6'h0c;
	localparam logic [5:0] addr_clocks_quad = 6'h06;
	localparam logic [5:0] mode_clocks_dual = 6'h04;
	localparam logic [5:0] mode_clocks_quad = 6'h02;
	localparam logic [5:0] long_idle_clocks = 6'h08;
	localparam logic [5:0] quad_io_idle_clocks = 6'h04;
	localparam logic [5:0] word_idle_clocks = 6'h02;
	// ==========================================================
	// field values and reset values
	localparam logic [1:0] opcode_skip_value = 2'h2;
	localparam logic [1:0] opcode_skip_reset = 2'h0;
	localparam logic [2:0] wrap_setting_reset = 3'h1;
	localparam logic [7:0] wrap_max_mask = 8'h3f;
	localparam logic [5:0] sync_reset_value = 6'h20; // cs high, link clock at its low idle level
	// ==========================================================
	// frame phases
	typedef enum {st_idle, st_opcode, st_addr, st_mode, st_dummy, st_data, st_ignore} phase_type;
endpackage

/* File: pin_sync.sv */
// two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync
	import flash_read_pkg::*;
#(
	parameter int width = 6,
	parameter logic [width-1:0] reset_value = '0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic [width-1:0] pin_in,
	output logic [width-1:0] pin_out
);
	logic [width-1:0] stage_one;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage_one <= reset_value;
			pin_out <= reset_value;
		end else if (clk_en) begin
			stage_one <= pin_in;
			pin_out <= stage_one;
		end
	end
endmodule

/* File: flash_read_path.sv */
// read-instruction front end: lane shifting, phase sequencing, wrap and continuous read
`timescale 1ns/1ps
module flash_read_path
	import flash_read_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic clk_en,
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] lane_in,
	output logic [3:0] lane_out,
	output logic [3:0] lane_oe_n,
	input wire logic four_lane_permit_bit,
	input wire logic busy,
	input wire logic wrap_load,
	input wire logic [2:0] wrap_value,
	output logic [2:0] wrap_setting,
	output logic continuous_mode,
	output logic [23:0] array_addr,
	output logic array_strobe,
	input wire logic [7:0] array_data
);
	// ==========================================================
	// pin sampling and edge finding
	logic [5:0] pin_s;
	logic sclk_prev;
	logic frame_start_ok;
	phase_type state, next_state;
	logic [5:0] cnt, next_cnt;
	logic [23:0] in_sr;
	logic [7:0] op;
	logic [7:0] out_sr;
	logic [3:0] out_left;
	logic drive_on;
	logic [1:0] opcode_skip_field;

	pin_sync #(.width(6), .reset_value(sync_reset_value)) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in({cs_n_pin, sclk_pin, lane_in}),
		.pin_out(pin_s)
	);

	// all pins share one synchroniser so lanes stay aligned with the clock edge
	wire cs_n_s = pin_s[5];
	wire sclk_s = pin_s[4];
	wire [3:0] lanes_s = pin_s[3:0];
	wire rise = clk_en & sclk_s & ~sclk_prev;
	wire fall = clk_en & ~sclk_s & sclk_prev;
	wire frame_end = clk_en & cs_n_s & (state != st_idle);

	// ==========================================================
	// decode of the registered opcode
	wire is_fast = (op == op_fast_read);
	wire is_dual_out = (op == op_dual_out);
	wire is_dual_io = (op == op_dual_io);
	wire is_quad_io = (op == op_quad_io);
	wire is_word = (op == op_word_quad);
	wire has_mode = is_dual_io | is_quad_io | is_word;
	wire [2:0] addr_lanes = is_dual_io ? 3'h2 : ((is_quad_io | is_word) ? 3'h4 : 3'h1);
	wire [2:0] data_lanes = is_fast ? 3'h1 : ((is_dual_out | is_dual_io) ? 3'h2 : 3'h4);
	wire [5:0] addr_len = (addr_lanes == 3'h1) ? addr_clocks_single :
		((addr_lanes == 3'h2) ? addr_clocks_dual : addr_clocks_quad);
	wire [5:0] mode_len = is_dual_io ? mode_clocks_dual : mode_clocks_quad;
	wire [5:0] dummy_len = is_quad_io ? quad_io_idle_clocks :
		(is_word ? word_idle_clocks : (is_dual_io ? 6'h00 : long_idle_clocks));
	wire [3:0] byte_clocks = (data_lanes == 3'h1) ? 4'h8 : ((data_lanes == 3'h2) ? 4'h4 : 4'h2);
	wire [3:0] drive_mask = (data_lanes == 3'h1) ? 4'h2 : ((data_lanes == 3'h2) ? 4'h3 : 4'hf);

	// ==========================================================
	// shifting in: width follows the phase, msb first, top lane holds the msb
	wire multi_in = (state == st_addr) | (state == st_mode);
	wire [2:0] shift_w = multi_in ? addr_lanes : 3'h1;
	wire [23:0] in_next = (shift_w == 3'h1) ? {in_sr[22:0], lanes_s[0]} :
		((shift_w == 3'h2) ? {in_sr[21:0], lanes_s[1:0]} : {in_sr[19:0], lanes_s});
	wire [7:0] op_in = in_next[7:0];

	// the opcode is taken only if known, permitted and the device is idle
	wire in_quad = (op_in == op_quad_out) | (op_in == op_quad_io) | (op_in == op_word_quad);
	wire in_known = in_quad | (op_in == op_fast_read) | (op_in == op_dual_out) |
		(op_in == op_dual_io);
	wire accept = in_known & (~in_quad | four_lane_permit_bit) & ~busy;
	wire cont_quad = is_quad_io | is_word;
	assign frame_start_ok = ~busy & (~cont_quad | four_lane_permit_bit);

	// ==========================================================
	// phase length and completion
	wire [5:0] phase_len = (state == st_opcode) ? opcode_clocks :
		((state == st_addr) ? addr_len :
		((state == st_mode) ? mode_len : ((state == st_dummy) ? dummy_len : 6'h00)));
	wire phase_done = (cnt == phase_len - 6'h01);

	// ==========================================================
	// wrap within an aligned section of the page, else plain increment
	wire wrap_off_bit = wrap_setting[0];
	wire [1:0] wrap_length_field = wrap_setting[2:1];
	wire wrap_use = (is_quad_io | is_word) & ~wrap_off_bit;
	wire [7:0] wrap_mask8 = wrap_max_mask >> (2'h3 - wrap_length_field);
	wire [23:0] wrap_mask = {16'h0000, wrap_mask8};
	wire [23:0] addr_inc = array_addr + 24'h000001;
	wire [23:0] next_addr = wrap_use ? ((array_addr & ~wrap_mask) | (addr_inc & wrap_mask)) :
		addr_inc;

	// ==========================================================
	// output byte selection on the falling edge
	wire [7:0] byte_now = (out_left == 4'h0) ? array_data : out_sr;
	wire [3:0] lane_bits = (data_lanes == 3'h1) ? {2'h0, byte_now[7], 1'h0} :
		((data_lanes == 3'h2) ? {2'h0, byte_now[7:6]} : byte_now[7:4]);
	wire [7:0] out_shift = (data_lanes == 3'h1) ? {byte_now[6:0], 1'h0} :
		((data_lanes == 3'h2) ? {byte_now[5:0], 2'h0} : {byte_now[3:0], 4'h0});
	wire [3:0] next_left = ((out_left == 4'h0) ? byte_clocks : out_left) - 4'h1;

	// phase sequencing, one step per rising link edge
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			st_idle: begin
				if (!cs_n_s) begin
					// continuous mode goes straight to the address
					next_state = continuous_mode ? (frame_start_ok ? st_addr : st_ignore) :
						st_opcode;
					next_cnt = 6'h00;
				end
			end
			st_opcode, st_addr, st_mode, st_dummy: begin
				if (rise) begin
					next_cnt = cnt + 6'h01;
					if (phase_done) begin
						next_cnt = 6'h00;
						if (state == st_opcode) begin
							next_state = accept ? st_addr : st_ignore;
						end else if (state == st_addr) begin
							next_state = has_mode ? st_mode : st_dummy;
						end else if (state == st_mode) begin
							next_state = (dummy_len == 6'h00) ? st_data : st_dummy;
						end else begin
							next_state = st_data;
						end
					end
				end
			end
			default: begin
				next_state = state;
			end
		endcase
		if (cs_n_s) begin
			next_state = st_idle;
		end
	end

	// state and counters; chip select high ends every frame
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state <= st_idle;
			cnt <= 6'h00;
			sclk_prev <= 1'b0;
		end else if (clk_en) begin
			state <= next_state;
			cnt <= next_cnt;
			sclk_prev <= sclk_s;
		end
	end

	// shift register, opcode and mode capture
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			in_sr <= 24'h000000;
			op <= 8'h00;
			opcode_skip_field <= opcode_skip_reset;
		end else if (rise && multi_in | (rise && state == st_opcode)) begin
			in_sr <= in_next;
			if (state == st_opcode && phase_done) begin
				op <= op_in;
			end
			// all-ones pattern lands here and sets bit four, leaving the mode
			if (state == st_mode && phase_done) begin
				opcode_skip_field <= in_next[5:4];
			end
		end
	end

	assign continuous_mode = (opcode_skip_field == opcode_skip_value);

	// wrap setting: loaded by the wrap command decoder outside this block
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrap_setting <= wrap_setting_reset;
		end else if (clk_en && wrap_load) begin
			wrap_setting <= wrap_value;
		end
	end

	// array address: loaded after the address phase, stepped per byte
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			array_addr <= 24'h000000;
			array_strobe <= 1'b0;
		end else if (clk_en) begin
			array_strobe <= 1'b0;
			if (rise && state == st_addr && phase_done) begin
				array_addr <= in_next;
			end else if (fall && state == st_data && out_left == 4'h0) begin
				array_addr <= next_addr;
				array_strobe <= 1'b1;
			end
		end
	end

	// output lanes: lanes stay released during idle clocks so no stale bit is seen
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			lane_out <= 4'h0;
			lane_oe_n <= 4'hf;
			out_sr <= 8'h00;
			out_left <= 4'h0;
			drive_on <= 1'b0;
		end else if (frame_end) begin
			lane_oe_n <= 4'hf;
			out_left <= 4'h0;
			drive_on <= 1'b0;
		end else if (fall && state == st_data) begin
			lane_out <= lane_bits;
			out_sr <= out_shift;
			out_left <= next_left;
			drive_on <= 1'b1;
			lane_oe_n <= ~drive_mask;
		end
	end

	// ==========================================================
	// checks
	logic [5:0] dummy_rises;
	always_ff @(posedge sys_clk) begin
		if (rst || state == st_idle) begin
			dummy_rises <= 6'h00;
		end else if (rise && state == st_dummy) begin
			dummy_rises <= dummy_rises + 6'h01;
		end
	end

	idle_released_a: assert property (@(posedge sys_clk) disable iff (rst)
		(state == st_dummy || state == st_addr) |-> lane_oe_n == 4'hf)
		else $error("lanes driven before data phase");
	single_lane_a: assert property (@(posedge sys_clk) disable iff (rst)
		(drive_on && is_fast) |-> lane_oe_n == 4'hd)
		else $error("fast read not on lane one alone");
	dual_lanes_a: assert property (@(posedge sys_clk) disable iff (rst)
		(drive_on && (is_dual_out || is_dual_io)) |-> lane_oe_n == 4'hc)
		else $error("dual read not on two lanes");
	quad_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		(rise && state == st_opcode && phase_done && in_quad && !four_lane_permit_bit
		&& !cs_n_s) |=> state == st_ignore)
		else $error("quad read taken without permit");
	busy_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
		(rise && state == st_opcode && phase_done && busy && !cs_n_s) |=> state == st_ignore)
		else $error("read taken while busy");
	idle_count_a: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(state == st_data) && $past(state) == st_dummy) |-> dummy_rises == dummy_len)
		else $error("wrong number of idle clocks");
	skip_opcode_a: assert property (@(posedge sys_clk) disable iff (rst)
		($past(state) == st_idle && state != st_idle && continuous_mode) |-> state != st_opcode)
		else $error("opcode expected in continuous mode");
	need_opcode_a: assert property (@(posedge sys_clk) disable iff (rst)
		($past(state) == st_idle && state != st_idle && !$past(continuous_mode))
		|-> state == st_opcode)
		else $error("opcode skipped outside continuous mode");
	addr_step_a: assert property (@(posedge sys_clk) disable iff (rst)
		(array_strobe && !wrap_use) |-> array_addr == $past(array_addr) + 24'h000001)
		else $error("address did not step by one");
	wrap_section_a: assert property (@(posedge sys_clk) disable iff (rst)
		(array_strobe && wrap_use) |-> (array_addr & ~wrap_mask) ==
		($past(array_addr) & ~wrap_mask))
		else $error("wrap left its section");
	wrap_reset_a: assert property (@(posedge sys_clk)
		$past(rst) |-> wrap_setting == wrap_setting_reset)
		else $error("wrap setting not reset to off");
	msb_first_a: assert property (@(posedge sys_clk) disable iff (rst)
		($rose(drive_on) && data_lanes == 3'h4) |-> lane_out == $past(array_data[7:4]))
		else $error("first nibble not most significant");

	quad_io_data_c: cover property (@(posedge sys_clk) disable iff (rst)
		drive_on && is_quad_io);
	cont_frame_c: cover property (@(posedge sys_clk) disable iff (rst)
		$past(state) == st_idle && state == st_addr);
	wrap_step_c: cover property (@(posedge sys_clk) disable iff (rst)
		array_strobe && wrap_use && array_addr[2:0] == 3'h0);
	word_read_c: cover property (@(posedge sys_clk) disable iff (rst)
		drive_on && is_word);
endmodule

/* File: host_model.sv */
// host controller model driving chip select, link clock and lanes
`timescale 1ns/1ps
module host_model (
	input wire logic [3:0] lane_line,
	output logic cs_n,
	output logic sclk,
	output logic [3:0] host_en,
	output logic [3:0] host_dat
);
	// ==========================================================
	// at rest: deselected, link clock low, every lane released
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		host_en = 4'h0;
		host_dat = 4'h0;
	end

	// ==========================================================
	// n link clocks of w bits each; drive on the fall, sample on the rise
	task automatic clocks(input int n, input int w, input logic [31:0] tx, input bit drv,
		inout logic [31:0] rx);
		for (int i = 0; i < n; i++) begin
			host_en = drv ? 4'((1 << w) - 1) : 4'h0;
			host_dat = 4'(tx >> ((n - 1 - i) * w));
			#32 sclk = 1'b1;
			rx = (rx << w) | ((w == 1) ? 32'(lane_line[1]) : 32'(lane_line & 4'((1 << w) - 1)));
			// hold past the rise, then free the lanes well before the fall
			#16 host_en = 4'h0;
			#16 sclk = 1'b0;
		end
	endtask

	// ==========================================================
	// one whole read frame; the gap after it lets the device see deselect
	task automatic frame(input logic [7:0] op, input bit send_op, input logic [23:0] addr,
		input int aw, input bit has_mode, input logic [7:0] mode, input int idle,
		input int dw, input int nb, output logic [31:0] rx);
		logic [31:0] d;
		d = '0;
		rx = '0;
		cs_n = 1'b0;
		#32;
		if (send_op) clocks(8, 1, 32'(op), 1'b1, d);
		clocks(24 / aw, aw, 32'(addr), 1'b1, d);
		if (has_mode) clocks(8 / aw, aw, 32'(mode), 1'b1, d);
		clocks(idle, 1, 32'h0, 1'b0, d);
		clocks(nb * 8 / dw, dw, 32'h0, 1'b0, rx);
		#32 cs_n = 1'b1;
		#320;
	endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the multi-lane flash read front end
`timescale 1ns/1ps
module testbench
	import flash_read_pkg::*;
;
	logic sys_clk, rst, busy, permit, wrap_load, idle_pat, cs_n, sclk, continuous_mode;
	logic array_strobe, clk_en;
	logic [2:0] wrap_value, wrap_setting;
	logic [3:0] lane_in, lane_out, lane_oe_n, host_en, host_dat;
	logic [23:0] array_addr;
	logic [7:0] array_data;
	logic [31:0] rx;
	int fail_count, cmp_count, strobes, drives;

	// ==========================================================
	// array contents are a fixed mix of the address bits
	function automatic logic [7:0] want_byte(input logic [23:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5a;
	endfunction
	// four bytes from a start address, stepping inside a section of mask+1
	function automatic logic [31:0] want(input logic [23:0] a, input logic [23:0] mask);
		logic [31:0] w;
		w = '0;
		for (int k = 0; k < 4; k++) begin
			w = {w[23:0], want_byte(a)};
			a = (a & ~mask) | ((a + 24'h1) & mask);
		end
		return w;
	endfunction
	assign array_data = want_byte(array_addr);

	// ==========================================================
	// wire level: device first, then host, else a line that wanders
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			lane_in[i] = !lane_oe_n[i] ? lane_out[i] : host_en[i] ? host_dat[i] : idle_pat;
		end
	end
	// clock, wander pattern and activity counters
	initial sys_clk = 1'b0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		idle_pat <= ~idle_pat;
		strobes <= strobes + int'(array_strobe);
		drives <= drives + int'(lane_oe_n != 4'hf);
	end

	flash_read_path flash_read_path_i (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
		.cs_n_pin(cs_n), .sclk_pin(sclk), .lane_in(lane_in), .lane_out(lane_out),
		.lane_oe_n(lane_oe_n), .four_lane_permit_bit(permit), .busy(busy),
		.wrap_load(wrap_load), .wrap_value(wrap_value), .wrap_setting(wrap_setting),
		.continuous_mode(continuous_mode), .array_addr(array_addr),
		.array_strobe(array_strobe), .array_data(array_data));
	host_model host_model_i (.lane_line(lane_in), .cs_n(cs_n), .sclk(sclk),
		.host_en(host_en), .host_dat(host_dat));

	// ==========================================================
	// shared helpers
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [7:0] op, input bit so, input logic [23:0] a, input int aw,
		input bit hm, input logic [7:0] m, input int idle, input int dw, input int nb);
		host_model_i.frame(op, so, a, aw, hm, m, idle, dw, nb, rx);
	endtask
	task automatic set_in(input logic p, input logic b);
		@(posedge sys_clk) #1;
		permit = p;
		busy = b;
	endtask
	task automatic load_wrap(input logic [2:0] v);
		@(posedge sys_clk) #1;
		wrap_value = v;
		wrap_load = 1'b1;
		@(posedge sys_clk) #1;
		wrap_load = 1'b0;
	endtask
	// a refused frame leaves the lanes released and the array untouched
	task automatic refused(input logic [7:0] op, input int aw, input bit hm, input int idle,
		input int dw);
		int s, d;
		s = strobes;
		d = drives;
		rd(op, 1'b1, 24'h000040, aw, hm, 8'h00, idle, dw, 2);
		check(32'(strobes - s), 32'h0);
		check(32'(drives - d), 32'h0);
	endtask

	// ==========================================================
	// output-only reads, the fast read crossing a page boundary; quad needs the permit
	task automatic t_out_reads();
		rd(op_fast_read, 1'b1, 24'h0000fe, 1, 1'b0, 8'h00, 8, 1, 4);
		check(rx, want(24'h0000fe, 24'hffffff));
		rd(op_dual_out, 1'b1, 24'h012345, 1, 1'b0, 8'h00, 8, 2, 4);
		check(rx, want(24'h012345, 24'hffffff));
		set_in(1'b1, 1'b0);
		rd(op_quad_out, 1'b1, 24'h00abcd, 1, 1'b0, 8'h00, 8, 4, 4);
		check(rx, want(24'h00abcd, 24'hffffff));
		set_in(1'b0, 1'b0);
		refused(op_quad_out, 1, 1'b0, 8, 4);
	endtask
	// two-lane address reads: opcode skipping, its end, and the 16-clock exit
	task automatic t_dual_io();
		rd(op_dual_io, 1'b1, 24'h00a0b1, 2, 1'b1, 8'h2f, 0, 2, 4);
		check(rx, want(24'h00a0b1, 24'hffffff));
		check(32'(continuous_mode), 32'h1);
		rd(8'h00, 1'b0, 24'h00c0d2, 2, 1'b1, 8'h10, 0, 2, 4);
		check(rx, want(24'h00c0d2, 24'hffffff));
		check(32'(continuous_mode), 32'h0);
		rd(op_fast_read, 1'b1, 24'h000010, 1, 1'b0, 8'h00, 8, 1, 4);
		check(rx, want(24'h000010, 24'hffffff));
		rd(op_dual_io, 1'b1, 24'h000020, 2, 1'b1, 8'h20, 0, 2, 4);
		rd(8'h00, 1'b0, 24'hffffff, 2, 1'b1, 8'hff, 0, 2, 0);
		check(32'(continuous_mode), 32'h0);
	endtask
	// four-lane address reads, word read, eight-clock exit, permit refusals
	task automatic t_quad_io();
		set_in(1'b1, 1'b0);
		rd(op_quad_io, 1'b1, 24'h003456, 4, 1'b1, 8'h20, 4, 4, 4);
		check(rx, want(24'h003456, 24'hffffff));
		check(32'(continuous_mode), 32'h1);
		rd(8'h00, 1'b0, 24'hffffff, 4, 1'b1, 8'hff, 0, 4, 0);
		check(32'(continuous_mode), 32'h0);
		rd(op_word_quad, 1'b1, 24'h000222, 4, 1'b1, 8'h20, 2, 4, 4);
		check(rx, want(24'h000222, 24'hffffff));
		rd(8'h00, 1'b0, 24'h000224, 4, 1'b1, 8'hef, 2, 4, 4);
		check(rx, want(24'h000224, 24'hffffff));
		rd(8'h00, 1'b0, 24'hffffff, 4, 1'b1, 8'hff, 0, 4, 0);
		check(32'(continuous_mode), 32'h0);
		set_in(1'b0, 1'b0);
		refused(op_quad_io, 4, 1'b1, 4, 4);
		refused(op_word_quad, 4, 1'b1, 2, 4);
	endtask
	// every wrap length, starting two bytes before the section end
	task automatic t_wrap();
		logic [23:0] s;
		check(32'(wrap_setting), 32'h1);
		set_in(1'b1, 1'b0);
		for (int l = 0; l < 4; l++) begin
			load_wrap(3'(l << 1));
			check(32'(wrap_setting), 32'(l << 1));
			s = 24'h000100 + (24'h8 << l) - 24'h2;
			rd(op_quad_io, 1'b1, s, 4, 1'b1, 8'h00, 4, 4, 4);
			check(rx, want(s, (24'h8 << l) - 24'h1));
		end
		load_wrap(3'h1);
		rd(op_quad_io, 1'b1, 24'h000106, 4, 1'b1, 8'h00, 4, 4, 4);
		check(rx, want(24'h000106, 24'hffffff));
	endtask
	// clock enable low freezes the wrap setting against a load
	task automatic t_freeze();
		@(posedge sys_clk) #1;
		clk_en = 1'b0;
		load_wrap(3'h0);
		check(32'(wrap_setting), 32'h1);
		@(posedge sys_clk) #1;
		clk_en = 1'b1;
	endtask
	// a read during a program cycle is ignored
	task automatic t_busy();
		set_in(1'b0, 1'b1);
		refused(op_fast_read, 1, 1'b0, 8, 1);
		set_in(1'b0, 1'b0);
	endtask

	// ==========================================================
	// verdict: the one place where the run ends
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// main sequence after ten cycles of reset
	initial begin
		fail_count = 0;
		cmp_count = 0;
		strobes = 0;
		drives = 0;
		idle_pat = 1'b0;
		rst = 1'b1;
		busy = 1'b0;
		permit = 1'b0;
		wrap_load = 1'b0;
		wrap_value = 3'h1;
		clk_en = 1'b1;
		repeat (10) @(posedge sys_clk);
		#1 rst = 1'b0;
		repeat (3) @(posedge sys_clk);
		t_out_reads();
		t_dual_io();
		t_quad_io();
		t_freeze();
		t_wrap();
		t_busy();
		give_verdict();
	end
	// watchdog, about three and a half times the span the frames should take
	initial begin
		#200000;
		fail_count++;
		give_verdict();
	end
endmodule
